// file: shared/dram_ctl_pkg.sv
// package for the page/nibble dram access controller
// assumes a 25 MHz system clock; the dram itself has no clock
package dram_ctl_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  // nibble cycle time, one full column-strobe toggle
  localparam int unsigned NIBBLE_CYCLE_NS = 50;
  // half cycles of the column strobe, rounded up, at least one clock
  localparam int unsigned NIB_HALF_NS = (NIBBLE_CYCLE_NS + 1) / 2;
  localparam int unsigned NIB_HALF_CYC =
    (NIB_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // row to column delay, precharge, strobe-low width, in clocks
  localparam int unsigned RCD_CYC   = 2;
  localparam int unsigned PRE_CYC   = 2;
  localparam int unsigned CAS_CYC   = 1;
  localparam int unsigned ADDR_W    = 10;
  localparam int unsigned CNT_W     = 4;

  // command codes
  typedef enum logic [1:0] {
    CMD_PAGE   = 2'h0,
    CMD_NIBBLE = 2'h1,
    CMD_CLOSE  = 2'h2
  } cmd_t;

  typedef struct packed {
    cmd_t                cmd;
    logic                write;
    logic [ADDR_W-1:0]   row;
    logic [ADDR_W-1:0]   col;
    logic                wdata;
  } req_t;

  typedef struct packed {
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
  } dram_pins_t;

  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;

endpackage : dram_ctl_pkg

// file: hw/dram_page_nibble_ctl.sv
// controller driving a multiplexed-address dram in page and nibble mode
// assumes requests from logic on i_sys_clk and the dram data pin on a wire
//
// Functional notes
// - keep row strobe low throughout a page run so columns share one row
// - column strobe fall reads or writes the cell chosen by write enable
// - between page accesses raise column strobe, new address, lower again
// - nibble run opens with an ordinary access, then column strobe toggles
// - in nibble runs tie top address pin low so the stepped top bits start at zero
// - row latched on row strobe fall, column on column strobe fall
`timescale 1ns/100ps
`default_nettype none

module dram_page_nibble_ctl #(
  parameter int unsigned ADDR_W = dram_ctl_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  // request side
  input  wire logic                i_req_valid,
  input  var  dram_ctl_pkg::req_t  i_req,
  output logic                     o_req_ready,
  output logic                     o_rd_valid,
  output logic                     o_rd_data,
  output logic [1:0]               o_nib_step,
  // dram pins
  output var  dram_ctl_pkg::dram_pins_t o_dram,
  input  wire logic                i_dq,
  output logic                     o_dq,
  output logic                     o_dq_oe
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RCD   = 3'h1,
    ST_CAS   = 3'h2,
    ST_OPEN  = 3'h3,
    ST_CASHI = 3'h4,
    ST_PRE   = 3'h5
  } state_t;

  state_t                              state_q;
  logic [dram_ctl_pkg::CNT_W-1:0]      cnt_q;
  logic                                nib_q;
  logic                                wr_q;
  logic [ADDR_W-1:0]                   col_q;
  logic                                dq_meta_q;
  logic                                dq_sync_q;
  logic                                rd_pend_q;
  logic                                rd_wait_q;
  // request addresses after the nibble-mode top-pin rule
  logic [ADDR_W-1:0]                   row_eff;
  logic [ADDR_W-1:0]                   col_eff;

  localparam logic [dram_ctl_pkg::CNT_W-1:0] RCD_N =
    dram_ctl_pkg::CNT_W'(dram_ctl_pkg::RCD_CYC);
  localparam logic [dram_ctl_pkg::CNT_W-1:0] PRE_N =
    dram_ctl_pkg::CNT_W'(dram_ctl_pkg::PRE_CYC);
  localparam logic [dram_ctl_pkg::CNT_W-1:0] CAS_N =
    dram_ctl_pkg::CNT_W'(dram_ctl_pkg::CAS_CYC);
  localparam logic [dram_ctl_pkg::CNT_W-1:0] NIB_N =
    dram_ctl_pkg::CNT_W'(dram_ctl_pkg::NIB_HALF_CYC);

  // nibble runs hold the top address pin low so the stepped top bits start at zero
  always_comb begin
    row_eff = i_req.row;
    col_eff = i_req.col;
    if (i_req.cmd == dram_ctl_pkg::CMD_NIBBLE) begin
      row_eff[ADDR_W-1] = 1'b0;
      col_eff[ADDR_W-1] = 1'b0;
    end
  end

  // data pin synchroniser
  // only the second flop feeds the read capture
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_meta_q <= 1'b0;
      dq_sync_q <= 1'b0;
    end else begin
      dq_meta_q <= i_dq;
      dq_sync_q <= dq_meta_q;
    end
  end

  // sequencer and strobes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q       <= ST_IDLE;
      cnt_q         <= '0;
      nib_q         <= 1'b0;
      wr_q          <= 1'b0;
      col_q         <= dram_ctl_pkg::ADDR_RST;
      o_dram.ras_n  <= 1'b1;
      o_dram.cas_n  <= 1'b1;
      o_dram.we_n   <= 1'b1;
      o_dram.addr   <= dram_ctl_pkg::ADDR_RST;
      o_req_ready   <= 1'b0;
      o_dq          <= 1'b0;
      o_dq_oe       <= 1'b0;
      o_nib_step    <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // a close with no open row is taken and dropped
          o_req_ready <= 1'b1;
          if (i_req_valid && o_req_ready &&
              i_req.cmd != dram_ctl_pkg::CMD_CLOSE) begin
            o_req_ready  <= 1'b0;
            o_dram.addr  <= row_eff;
            o_dram.ras_n <= 1'b0;
            nib_q        <= (i_req.cmd == dram_ctl_pkg::CMD_NIBBLE);
            wr_q         <= i_req.write;
            col_q        <= col_eff;
            o_dq         <= i_req.wdata;
            o_dq_oe      <= i_req.write;
            o_nib_step   <= 2'h0;
            cnt_q        <= RCD_N;
            state_q      <= ST_RCD;
          end
        end
        ST_RCD: begin
          o_dram.addr <= col_q;
          o_dram.we_n <= ~wr_q;
          if (cnt_q <= 4'h1) begin
            o_dram.cas_n <= 1'b0;
            cnt_q        <= nib_q ? NIB_N : CAS_N;
            state_q      <= ST_CAS;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_CAS: begin
          if (cnt_q <= 4'h1) begin
            o_dram.cas_n <= 1'b1;
            o_dram.we_n  <= 1'b1;
            o_req_ready  <= 1'b1;
            state_q      <= ST_OPEN;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_OPEN: begin
          // row stays open while more accesses come
          if (i_req_valid && o_req_ready) begin
            o_req_ready <= 1'b0;
            if (i_req.cmd == dram_ctl_pkg::CMD_CLOSE ||
                (!nib_q && i_req.cmd != dram_ctl_pkg::CMD_PAGE)) begin
              o_dram.ras_n <= 1'b1;
              o_dq_oe      <= 1'b0;
              cnt_q        <= PRE_N;
              state_q      <= ST_PRE;
            end else begin
              // nibble toggles reuse latched address
              if (!nib_q) begin
                o_dram.addr <= i_req.col;
              end
              wr_q        <= i_req.write;
              o_dram.we_n <= ~i_req.write;
              o_dq        <= i_req.wdata;
              o_dq_oe     <= i_req.write;
              cnt_q       <= nib_q ? NIB_N : CAS_N;
              state_q     <= ST_CASHI;
            end
          end
        end
        ST_CASHI: begin
          // strobe was high one clock with address set up
          o_dram.cas_n <= 1'b0;
          if (nib_q) begin
            o_nib_step <= o_nib_step + 2'h1;
          end
          state_q <= ST_CAS;
        end
        ST_PRE: begin
          // row strobe stays high for the precharge count
          if (cnt_q <= 4'h1) begin
            nib_q       <= 1'b0;
            o_nib_step  <= 2'h0;
            o_req_ready <= 1'b1;
            state_q     <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read data capture at the end of each read strobe-low phase
  // the pin is sampled as the strobe rises and needs two more clocks
  // through the synchroniser before the capture may take it
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_pend_q  <= 1'b0;
      rd_wait_q  <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data  <= 1'b0;
    end else begin
      rd_pend_q  <= (state_q == ST_CAS) && (cnt_q <= 4'h1) && !wr_q;
      rd_wait_q  <= rd_pend_q;
      o_rd_valid <= rd_wait_q;
      if (rd_wait_q) begin
        o_rd_data <= dq_sync_q;
      end
    end
  end

endmodule : dram_page_nibble_ctl

`default_nettype wire

// file: testbench/dram_ctl_sva.sv
// pin timing checks for the page/nibble dram controller
// assumes a bind to the controller's ports
`timescale 1ns/100ps
`default_nettype none
module dram_ctl_sva (
  input wire logic                 i_sys_clk,
  input wire logic                 i_rst_n,
  input wire logic                 o_req_ready,
  input wire logic                 o_rd_valid,
  input wire logic [1:0]           o_nib_step,
  input var  dram_ctl_pkg::dram_pins_t o_dram
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_CAS_IN_ROW: assert property (!o_dram.cas_n |-> !o_dram.ras_n)
    else $error("column strobe low without open row");
  AST_ROW_FIRST: assert property ($fell(o_dram.ras_n) |-> o_dram.cas_n [*2])
    else $error("column strobe too soon after row strobe");
  AST_COL_SETUP: assert property ($fell(o_dram.cas_n) |->
    $stable(o_dram.addr) && $stable(o_dram.we_n))
    else $error("address or write enable moved at column strobe");
  AST_CAS_PULSE: assert property ($fell(o_dram.cas_n) |=> $rose(o_dram.cas_n))
    else $error("column strobe low too long");
  AST_BUSY: assert property ($fell(o_dram.cas_n) |-> !o_req_ready)
    else $error("ready during column access");
  AST_RD_LAT: assert property ($rose(o_dram.cas_n) && $past(o_dram.we_n)
    && !o_dram.ras_n |-> ##2 o_rd_valid)
    else $error("read result late or missing");
  AST_NIB_TOP: assert property (!o_dram.cas_n && o_nib_step != 2'h0 |->
    !o_dram.addr[dram_ctl_pkg::ADDR_W-1])
    else $error("top address pin high during nibble toggle");
  cover property (o_nib_step == 2'h3);
  cover property ($fell(o_dram.ras_n));
  cover property (o_rd_valid);
  cover property ($rose(o_dram.ras_n));
endmodule : dram_ctl_sva
`default_nettype wire

// file: testbench/dram_model.sv
// behavioural dram with page and nibble column access
// assumes i_nib is set by the bench for nibble runs
`timescale 1ns/100ps
`default_nettype none
module dram_model (
  input wire logic                 i_nib,
  input var  dram_ctl_pkg::dram_pins_t i_pins,
  input wire logic                 i_dq,
  output logic                     o_dq,
  output logic                     o_fast
);
  logic       mem [0:1048575];
  logic [9:0] row;
  logic [9:0] col;
  logic [1:0] st = 2'h0;
  logic       q = 1'b0;
  logic       fast = 1'b0;
  logic       ras_d = 1'b1;
  logic       cas_d = 1'b1;
  realtime    t_fall = 0.0;
  bit [19:0]  k;
  // one process watches both strobes; the short wait lets the pins settle
  always @(i_pins.ras_n or i_pins.cas_n) begin
    #1;
    if (ras_d && !i_pins.ras_n) begin
      row = i_pins.addr;
      st = 2'h0;
    end
    if (cas_d && !i_pins.cas_n) begin
      if (i_nib && st != 2'h0 &&
          $realtime - t_fall < dram_ctl_pkg::NIBBLE_CYCLE_NS)
        fast = 1'b1;
      t_fall = $realtime;
      if (!i_nib || st == 2'h0) col = i_pins.addr;
      k = {row[9] ^ st[0], row[8:0], col[9] ^ st[1], col[8:0]};
      if (!i_pins.we_n) mem[k] = i_dq;
      else q = mem[k];
      if (i_nib) st = st + 2'h1;
    end else if (!cas_d && i_pins.cas_n) begin
      // released line shows the inverse of the last value
      q = ~q;
    end
    ras_d = i_pins.ras_n;
    cas_d = i_pins.cas_n;
  end
  assign o_dq = q;
  assign o_fast = fast;
endmodule : dram_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the page/nibble dram controller
// assumes the behavioural dram model on the pins
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic clk = 0, rst_n = 0, valid = 0, nib = 0;
  logic ready, rv, rdat, dq, dq_oe, mdq, fast;
  logic [1:0] step;
  dram_ctl_pkg::req_t req = '0;
  dram_ctl_pkg::dram_pins_t pins;
  int fails = 0, checks_done = 0;
  wire logic line = dq_oe ? dq : mdq;
  always #20 clk = ~clk;
  dram_page_nibble_ctl dut (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_req_valid(valid), .i_req(req), .o_req_ready(ready), .o_rd_valid(rv),
    .o_rd_data(rdat), .o_nib_step(step), .o_dram(pins), .i_dq(line),
    .o_dq(dq), .o_dq_oe(dq_oe));
  dram_model mem (.i_nib(nib), .i_pins(pins), .i_dq(line), .o_dq(mdq),
    .o_fast(fast));
  task go(input dram_ctl_pkg::cmd_t c, input logic w,
          input logic [9:0] r, input logic [9:0] cl, input logic d);
    int n;
    n = 0;
    while (!ready && n < 50) begin @(negedge clk); n++; end
    `CHK(ready, 1'b1)
    req = '{c, w, r, cl, d};
    valid = 1;
    @(negedge clk);
    valid = 0;
  endtask : go
  task rd(input logic e);
    int n;
    n = 0;
    while (!rv && n < 50) begin @(negedge clk); n++; end
    `CHK(rv, 1'b1)
    `CHK(rdat, e)
  endtask : rd
  task step_is(input logic [1:0] e);
    int n;
    n = 0;
    while (!ready && n < 50) begin @(negedge clk); n++; end
    `CHK(step, e)
  endtask : step_is
  task page_run;
    go(dram_ctl_pkg::CMD_PAGE, 1, 10'h005, 10'h001, 1);
    go(dram_ctl_pkg::CMD_PAGE, 1, 10'h005, 10'h002, 0);
    go(dram_ctl_pkg::CMD_PAGE, 0, 10'h005, 10'h001, 0);
    rd(1);
    go(dram_ctl_pkg::CMD_PAGE, 0, 10'h005, 10'h002, 0);
    rd(0);
    go(dram_ctl_pkg::CMD_CLOSE, 0, 10'h000, 10'h000, 0);
  endtask : page_run
  task nib_run;
    nib = 1;
    go(dram_ctl_pkg::CMD_NIBBLE, 1, 10'h200, 10'h200, 1);
    step_is(2'h0);
    go(dram_ctl_pkg::CMD_NIBBLE, 1, 10'h000, 10'h000, 0);
    step_is(2'h1);
    go(dram_ctl_pkg::CMD_NIBBLE, 1, 10'h000, 10'h000, 1);
    step_is(2'h2);
    go(dram_ctl_pkg::CMD_NIBBLE, 1, 10'h000, 10'h000, 0);
    step_is(2'h3);
    go(dram_ctl_pkg::CMD_NIBBLE, 0, 10'h000, 10'h000, 0);
    rd(1);
    step_is(2'h0);
    `CHK(fast, 1'b0)
    go(dram_ctl_pkg::CMD_CLOSE, 0, 10'h000, 10'h000, 0);
    nib = 0;
    go(dram_ctl_pkg::CMD_PAGE, 0, 10'h000, 10'h200, 0);
    rd(1);
    go(dram_ctl_pkg::CMD_CLOSE, 0, 10'h000, 10'h000, 0);
    go(dram_ctl_pkg::CMD_PAGE, 0, 10'h200, 10'h000, 0);
    rd(0);
    go(dram_ctl_pkg::CMD_PAGE, 0, 10'h200, 10'h200, 0);
    rd(0);
    go(dram_ctl_pkg::CMD_CLOSE, 0, 10'h000, 10'h000, 0);
  endtask : nib_run
  task results;
    $display("fails %0d checks %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    page_run;
    nib_run;
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    results;
  end
endmodule : tb_top
bind dram_page_nibble_ctl dram_ctl_sva chk (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
  .o_nib_step(o_nib_step), .o_dram(o_dram));
`default_nettype wire
